// >>> design/cmu_top.sv
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "cmu_params.svh"
// Functional notes
// - effective address is base register plus sign-extended 12-bit offset
// - address ops on virtual caches may translate and take TLB faults
// - address ops on physical caches translate first, then use physical address
// - index ops translate; index source is a control bit
// - way and index come from boundaries derived from cache geometry
// - direct-mapped cache ignores the way field
// - TLB faults carry the load cause only; never modified or store cause
// - any byte alignment is accepted without address error
// - writeback faults give cache error; bus error on failed bus transfer
// - index load tag never raises cache error
// - optional address error with load cause for protected kernel region
// - instruction completes only after a memory barrier drains its traffic
// - cache select bits 22:21 pick instruction, data, tertiary, secondary
// - operation comes from bits 25:23
// - outer cache operations handle the inner data cache first; here code 001 reads the outer level directly
// - hit operations broadcast only with a coherent attribute
// - all levels of one instruction share the same broadcast choice
// - code 000 on instruction cache invalidates the indexed block
// - code 000 on data cache writes back dirty blocks, then invalidates; no writeback here while CMU_CTRL_WT_DATA is set
// - code 000 is supported on secondary and tertiary caches
// - code 001 loads indexed tag and data into the holding registers
// - coprocessor unusable when control access is disabled
module cmu_top (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite register slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// pipeline issue
	input wire logic iss_valid,
	input wire logic [31:0] iss_instr,
	input wire logic [31:0] iss_base,
	input wire logic iss_cp0_usable,
	input wire logic iss_user_mode,
	output logic iss_stall,
	output logic iss_done,
	output logic iss_exc,
	output cmu_pkg::cmu_exc_t iss_exc_code,
	// translation unit
	output logic tlb_req,
	output logic [31:0] tlb_vaddr,
	input wire logic tlb_ack,
	input wire logic [31:0] tlb_paddr,
	input wire logic tlb_refill,
	input wire logic tlb_invalid,
	input wire logic tlb_coherent,
	// cache array port
	output logic cache_req,
	output logic [1:0] cache_sel,
	output cmu_pkg::cmu_cop_t cache_op,
	output logic [31:0] cache_addr,
	output logic [1:0] cache_way,
	output logic [8:0] cache_index,
	output logic cache_global,
	input wire logic cache_ack,
	input wire logic cache_valid,
	input wire logic cache_dirty,
	input wire logic cache_err,
	input wire logic [31:0] cache_tag_lo,
	input wire logic [31:0] cache_tag_hi,
	input wire logic [31:0] cache_data_lo,
	input wire logic [31:0] cache_data_hi,
	// writeback bus and barrier
	output logic bus_req,
	output logic [31:0] bus_addr,
	input wire logic bus_ack,
	input wire logic bus_err,
	output logic sync_req,
	input wire logic sync_ack
);
	// ====================================================
	// geometry
	localparam int OFF_BIT = $clog2(`CMU_BYTES_PER_TAG);
	localparam int IDX_BIT = $clog2(`CMU_CACHE_BYTES / `CMU_ASSOC);
	localparam int WAY_BIT = IDX_BIT + $clog2(`CMU_ASSOC);
	localparam int IDX_W = IDX_BIT - OFF_BIT;

	function automatic logic [1:0] way_of(input logic [31:0] a);
		if (`CMU_ASSOC == 1) begin
			way_of = 2'h0;
		end else begin
			way_of = 2'(a[WAY_BIT-1:IDX_BIT]);
		end
	endfunction : way_of

	function automatic logic [8:0] index_of(input logic [31:0] a);
		index_of = 9'(a[IDX_BIT-1:OFF_BIT]);
	endfunction : index_of

	// ====================================================
	// sequencer
	typedef enum logic [2:0] {
		ST_IDLE, ST_XLATE, ST_LOOKUP, ST_WBACK, ST_INVAL, ST_LDTAG, ST_SYNC
	} cmu_state_t;

	cmu_state_t state_q;
	logic [31:0] vaddr_q;
	logic [31:0] paddr_q;
	logic [2:0] op_q;
	logic [1:0] sel_q;
	logic [1:0] level_q;
	logic outer_q;
	logic global_q;
	logic [31:0] wb_tag_q;
	logic [2:0] ctrl_q;
	logic [31:0] vaddr_d;
	logic [31:0] idx_src;
	logic kern_fault;

	// sign extension of the offset field
	assign vaddr_d = iss_base + {{(32-`CMU_OFFSET_W){iss_instr[`CMU_OFFSET_W-1]}},
		iss_instr[`CMU_OFFSET_W-1:0]};
	// no alignment check anywhere, so any byte address passes
	assign kern_fault = ctrl_q[`CMU_CTRL_KCHK] & iss_user_mode & vaddr_q[`CMU_KERNEL_BIT];
	assign idx_src = ctrl_q[`CMU_CTRL_IDX_PHYS] ? paddr_q : vaddr_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
			vaddr_q <= 32'h0;
			paddr_q <= 32'h0;
			op_q <= 3'h0;
			sel_q <= 2'h0;
			level_q <= 2'h0;
			outer_q <= 1'b0;
			global_q <= 1'b0;
			wb_tag_q <= 32'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					// the done cycle still stalls the pipeline, so nothing is taken then
					if (iss_valid && iss_cp0_usable && !iss_done) begin
						vaddr_q <= vaddr_d;
						op_q <= iss_instr[`CMU_OP_HI:`CMU_OP_LO];
						sel_q <= iss_instr[`CMU_SEL_HI:`CMU_SEL_LO];
						state_q <= ST_XLATE;
					end
				end
				ST_XLATE: begin
					if (tlb_ack) begin
						paddr_q <= tlb_paddr;
						// index ops are never hit type, so no broadcast on any level
						global_q <= 1'b0;
						if (tlb_refill || tlb_invalid || kern_fault) begin
							state_q <= ST_IDLE;
						end else if (op_q == `CMU_OP_INDEX_LDTAG) begin
							level_q <= sel_q;
							state_q <= ST_LDTAG;
						end else if (op_q == `CMU_OP_INDEX_INVAL) begin
							// outer levels first clean the inner data cache
							outer_q <= (sel_q == `CMU_SEL_SEC) || (sel_q == `CMU_SEL_TER);
							level_q <= ((sel_q == `CMU_SEL_SEC) || (sel_q == `CMU_SEL_TER))
								? `CMU_SEL_PRI_D : sel_q;
							state_q <= ST_LOOKUP;
						end else begin
							// other codes are not built; they retire as no-ops
							state_q <= ST_SYNC;
						end
					end
				end
				ST_LOOKUP: begin
					if (cache_ack) begin
						// the tag only stands with the ack, so keep it for the writeback
						wb_tag_q <= cache_tag_lo;
						if (cache_err) begin
							state_q <= ST_IDLE;
						end else if (cache_valid && cache_dirty && (level_q != `CMU_SEL_PRI_I)
							&& !ctrl_q[`CMU_CTRL_WT_DATA]) begin
							state_q <= ST_WBACK;
						end else begin
							state_q <= ST_INVAL;
						end
					end
				end
				ST_WBACK: begin
					if (bus_ack) begin
						state_q <= bus_err ? ST_IDLE : ST_INVAL;
					end
				end
				ST_INVAL: begin
					if (cache_ack) begin
						if (cache_err) begin
							state_q <= ST_IDLE;
						end else if (outer_q) begin
							outer_q <= 1'b0;
							level_q <= sel_q;
							state_q <= ST_LOOKUP;
						end else begin
							state_q <= ST_SYNC;
						end
					end
				end
				ST_LDTAG: begin
					// cache_err ignored here by design
					if (cache_ack) begin
						state_q <= ST_SYNC;
					end
				end
				ST_SYNC: begin
					if (sync_ack) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ====================================================
	// completion and exceptions
	cmu_pkg::cmu_exc_t exc_d;
	logic fin_d;

	always_comb begin
		exc_d = cmu_pkg::CMU_EXC_NONE;
		fin_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (iss_valid && !iss_cp0_usable && !iss_done) begin
					exc_d = cmu_pkg::CMU_EXC_CPU;
				end
			end
			ST_XLATE: begin
				if (tlb_ack && tlb_refill) begin
					exc_d = cmu_pkg::CMU_EXC_TLB_REFILL;
				end else if (tlb_ack && tlb_invalid) begin
					exc_d = cmu_pkg::CMU_EXC_TLB_INVALID;
				end else if (tlb_ack && kern_fault) begin
					exc_d = cmu_pkg::CMU_EXC_ADDR_LOAD;
				end
			end
			ST_LOOKUP, ST_INVAL: begin
				if (cache_ack && cache_err) begin
					exc_d = cmu_pkg::CMU_EXC_CACHE_ERR;
				end
			end
			ST_WBACK: begin
				if (bus_ack && bus_err) begin
					exc_d = cmu_pkg::CMU_EXC_BUS_ERR;
				end
			end
			ST_SYNC: begin
				fin_d = sync_ack;
			end
			default: begin
				fin_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			iss_done <= 1'b0;
			iss_exc <= 1'b0;
			iss_exc_code <= cmu_pkg::CMU_EXC_NONE;
		end else begin
			iss_done <= fin_d || (exc_d != cmu_pkg::CMU_EXC_NONE);
			iss_exc <= exc_d != cmu_pkg::CMU_EXC_NONE;
			if (exc_d != cmu_pkg::CMU_EXC_NONE) begin
				iss_exc_code <= exc_d;
			end
		end
	end

	// held until the done pulse so the pipeline cannot issue over us
	assign iss_stall = (state_q != ST_IDLE) || iss_done;

	// ====================================================
	// side requests
	assign tlb_req = state_q == ST_XLATE;
	assign tlb_vaddr = vaddr_q;
	assign cache_req = (state_q == ST_LOOKUP) || (state_q == ST_INVAL) || (state_q == ST_LDTAG);
	assign cache_sel = level_q;
	assign cache_op = (state_q == ST_LDTAG) ? cmu_pkg::CMU_COP_LDTAG :
		(state_q == ST_INVAL) ? cmu_pkg::CMU_COP_INVAL : cmu_pkg::CMU_COP_LOOKUP;
	assign cache_addr = idx_src;
	assign cache_way = way_of(idx_src);
	assign cache_index = index_of(idx_src);
	assign cache_global = global_q;
	assign bus_req = state_q == ST_WBACK;
	// writeback goes to the block's tag bits above the index, joined with the index bits of the operation address
	assign bus_addr = {wb_tag_q[31:IDX_BIT], idx_src[IDX_BIT-1:OFF_BIT], OFF_BIT'(0)};
	assign sync_req = state_q == ST_SYNC;

	// ====================================================
	// register slave
	logic [`CMU_ADDR_W-1:0] wr_addr_q;
	logic wr_pend_q;
	logic [`CMU_ADDR_W-1:0] rd_addr_q;
	logic rd_wait_q;
	logic [31:0] tag_low_holding_reg_q;
	logic [31:0] tag_high_holding_reg_q;
	logic [31:0] line_data_low_reg_q;
	logic [31:0] line_data_high_reg_q;
	logic [31:0] count_q;
	logic [31:0] rd_val;
	logic addr_ph;
	logic ld_tag_fire;

	assign addr_ph = hsel && htrans[1] && hready;
	assign ld_tag_fire = (state_q == ST_LDTAG) && cache_ack;

	// reads take one wait state so a write just before is already visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			rd_wait_q <= 1'b0;
			rd_addr_q <= '0;
		end else begin
			wr_pend_q <= addr_ph && hwrite;
			rd_wait_q <= addr_ph && !hwrite;
			if (addr_ph) begin
				wr_addr_q <= haddr[`CMU_ADDR_W-1:0];
				rd_addr_q <= haddr[`CMU_ADDR_W-1:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `CMU_CTRL_RESET;
		end else if (wr_pend_q && wr_addr_q == `CMU_ADDR_W'(`CMU_REG_CTRL)) begin
			ctrl_q <= hwdata[2:0];
		end
	end

	// hardware load beats a software write in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tag_low_holding_reg_q <= 32'h0;
			tag_high_holding_reg_q <= 32'h0;
			line_data_low_reg_q <= 32'h0;
			line_data_high_reg_q <= 32'h0;
		end else if (ld_tag_fire) begin
			tag_low_holding_reg_q <= cache_tag_lo;
			tag_high_holding_reg_q <= cache_tag_hi;
			line_data_low_reg_q <= cache_data_lo;
			line_data_high_reg_q <= cache_data_hi;
		end else if (wr_pend_q) begin
			if (wr_addr_q == `CMU_ADDR_W'(`CMU_REG_TAG_LOW_HOLDING_REG)) begin
				tag_low_holding_reg_q <= hwdata;
			end else if (wr_addr_q == `CMU_ADDR_W'(`CMU_REG_TAG_HIGH_HOLDING_REG)) begin
				tag_high_holding_reg_q <= hwdata;
			end else if (wr_addr_q == `CMU_ADDR_W'(`CMU_REG_LINE_DATA_LOW_REG)) begin
				line_data_low_reg_q <= hwdata;
			end else if (wr_addr_q == `CMU_ADDR_W'(`CMU_REG_LINE_DATA_HIGH_REG)) begin
				line_data_high_reg_q <= hwdata;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= 32'h0;
		end else if (fin_d) begin
			count_q <= count_q + 32'h1;
		end
	end

	always_comb begin
		if (rd_addr_q == `CMU_ADDR_W'(`CMU_REG_CTRL)) begin
			rd_val = {29'h0, ctrl_q};
		end else if (rd_addr_q == `CMU_ADDR_W'(`CMU_REG_STATUS)) begin
			rd_val = {24'h0, 1'b0, iss_exc_code, 1'b0, state_q};
		end else if (rd_addr_q == `CMU_ADDR_W'(`CMU_REG_TAG_LOW_HOLDING_REG)) begin
			rd_val = tag_low_holding_reg_q;
		end else if (rd_addr_q == `CMU_ADDR_W'(`CMU_REG_TAG_HIGH_HOLDING_REG)) begin
			rd_val = tag_high_holding_reg_q;
		end else if (rd_addr_q == `CMU_ADDR_W'(`CMU_REG_LINE_DATA_LOW_REG)) begin
			rd_val = line_data_low_reg_q;
		end else if (rd_addr_q == `CMU_ADDR_W'(`CMU_REG_LINE_DATA_HIGH_REG)) begin
			rd_val = line_data_high_reg_q;
		end else if (rd_addr_q == `CMU_ADDR_W'(`CMU_REG_COUNT)) begin
			rd_val = count_q;
		end else begin
			rd_val = 32'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (rd_wait_q) begin
			hrdata <= rd_val;
		end
	end

	// ready drops for the first data-phase cycle of a read only
	logic rd_hold_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_hold_q <= 1'b0;
		end else begin
			rd_hold_q <= rd_wait_q;
		end
	end

	assign hreadyout = !rd_wait_q || rd_hold_q;
	assign hresp = 1'b0;

endmodule : cmu_top

// >>> design/cmu_params.svh
`ifndef CMU_PARAMS_SVH
`define CMU_PARAMS_SVH
// instruction fields
`define CMU_OFFSET_W 12
`define CMU_OP_HI 25
`define CMU_OP_LO 23
`define CMU_SEL_HI 22
`define CMU_SEL_LO 21
`define CMU_OP_INDEX_INVAL 3'h0
`define CMU_OP_INDEX_LDTAG 3'h1
`define CMU_SEL_PRI_I 2'h0
`define CMU_SEL_PRI_D 2'h1
`define CMU_SEL_TER 2'h2
`define CMU_SEL_SEC 2'h3
// cache geometry
`define CMU_BYTES_PER_TAG 32
`define CMU_CACHE_BYTES 16384
`define CMU_ASSOC 4
// protected kernel region: top address bit set while in user mode
`define CMU_KERNEL_BIT 31
// register byte offsets
`define CMU_REG_CTRL 32'h0000_0000
`define CMU_REG_STATUS 32'h0000_0004
`define CMU_REG_TAG_LOW_HOLDING_REG 32'h0000_0008
`define CMU_REG_TAG_HIGH_HOLDING_REG 32'h0000_000c
`define CMU_REG_LINE_DATA_LOW_REG 32'h0000_0010
`define CMU_REG_LINE_DATA_HIGH_REG 32'h0000_0014
`define CMU_REG_COUNT 32'h0000_0018
`define CMU_ADDR_W 5
`define CMU_CTRL_RESET 3'h0
// ctrl bits
`define CMU_CTRL_KCHK 0
`define CMU_CTRL_IDX_PHYS 1
`define CMU_CTRL_WT_DATA 2
`endif

// >>> design/cmu_pkg.sv
package cmu_pkg;
	typedef enum logic [2:0] {
		CMU_EXC_NONE,
		CMU_EXC_CPU,
		CMU_EXC_TLB_REFILL,
		CMU_EXC_TLB_INVALID,
		CMU_EXC_ADDR_LOAD,
		CMU_EXC_CACHE_ERR,
		CMU_EXC_BUS_ERR
	} cmu_exc_t;
	typedef enum logic [1:0] {
		CMU_COP_LOOKUP,
		CMU_COP_INVAL,
		CMU_COP_LDTAG
	} cmu_cop_t;
endpackage : cmu_pkg

// >>> bench/cmu_asserts.sv
`timescale 1ns/100ps
module cmu_asserts (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pipeline
	input wire logic iss_valid,
	input wire logic iss_cp0_usable,
	input wire logic iss_stall,
	input wire logic iss_done,
	input wire logic iss_exc,
	input wire cmu_pkg::cmu_exc_t iss_exc_code,
	// translation
	input wire logic tlb_ack,
	input wire logic tlb_refill,
	// cache, bus, barrier
	input wire logic cache_req,
	input wire logic [1:0] cache_sel,
	input wire cmu_pkg::cmu_cop_t cache_op,
	input wire logic [31:0] cache_addr,
	input wire logic [1:0] cache_way,
	input wire logic [8:0] cache_index,
	input wire logic cache_ack,
	input wire logic cache_valid,
	input wire logic cache_dirty,
	input wire logic cache_err,
	input wire logic bus_req,
	input wire logic sync_req,
	input wire logic sync_ack
);
	// ==========
	// checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_cpu_unusable: assert property (iss_valid && !iss_stall && !iss_cp0_usable
		|=> iss_done && iss_exc && iss_exc_code == cmu_pkg::CMU_EXC_CPU) else $error("no cp0 fault");
	a_refill_code: assert property (tlb_ack && tlb_refill |-> ##[1:2]
		iss_exc && iss_exc_code == cmu_pkg::CMU_EXC_TLB_REFILL) else $error("bad refill");
	a_fault_no_cache: assert property (tlb_ack && tlb_refill |-> !cache_req [*4])
		else $error("cache touched");
	a_way_index: assert property (cache_req |-> cache_way == cache_addr[13:12]
		&& cache_index == {2'h0, cache_addr[11:5]}) else $error("bad way or index");
	a_dirty_wb: assert property (cache_ack && cache_op == cmu_pkg::CMU_COP_LOOKUP
		&& cache_sel == 2'h1 && cache_valid && cache_dirty && !cache_err |-> ##[1:2] bus_req)
		else $error("no writeback");
	a_ldtag_quiet: assert property (cache_ack && cache_op == cmu_pkg::CMU_COP_LDTAG
		|=> !iss_exc [*4]) else $error("load tag faulted");
	a_cache_err: assert property (cache_ack && cache_err && cache_op != cmu_pkg::CMU_COP_LDTAG
		|-> ##[1:2] iss_exc && iss_exc_code == cmu_pkg::CMU_EXC_CACHE_ERR) else $error("no cache err");
	a_sync_done: assert property (sync_req && sync_ack |=> iss_done && !iss_exc)
		else $error("no done after barrier");
	c_refill: cover property (tlb_ack && tlb_refill);
	c_wb: cover property (bus_req);
	c_ldtag: cover property (cache_ack && cache_op == cmu_pkg::CMU_COP_LDTAG);
endmodule : cmu_asserts

// >>> bench/cmu_far_model.sv
`timescale 1ns/100ps
module cmu_far_model #(
	parameter logic [31:0] TAG = 32'h1234_5000
) (
	// clock, reset, knobs: 0 refill 1 invalid 2 dirty 3 cache err 4 bus err 5 slow
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [5:0] knob,
	// translation
	input wire logic tlb_req,
	input wire logic [31:0] tlb_vaddr,
	output logic tlb_ack,
	output logic [31:0] tlb_paddr,
	output logic tlb_refill,
	output logic tlb_invalid,
	// cache, bus, barrier
	input wire logic cache_req,
	output logic cache_ack,
	output logic cache_dirty,
	output logic cache_err,
	output logic [31:0] ctag,
	input wire logic bus_req,
	output logic bus_ack,
	output logic bus_err,
	input wire logic sync_req,
	output logic sync_ack
);
	logic [3:0] ack_q;
	logic [1:0] wait_q;
	logic pend, go;
	assign pend = |{sync_req, bus_req, cache_req, tlb_req};
	assign go = pend && ack_q == 4'h0 && wait_q == (knob[5] ? 2'h3 : 2'h0);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_q <= 4'h0;
			wait_q <= 2'h0;
		end else begin
			ack_q <= go ? {sync_req, bus_req, cache_req, tlb_req} : 4'h0;
			wait_q <= (pend && !go && ack_q == 4'h0) ? wait_q + 2'h1 : 2'h0;
		end
	end
	assign {sync_ack, bus_ack, cache_ack, tlb_ack} = ack_q;
	// answer lines only mean something with the ack, so paddr, tag and dirty flip elsewhere and the fault flags stay low
	// index bits of the physical address differ from the virtual ones, so the source shows
	assign tlb_paddr = tlb_ack ? (tlb_vaddr ^ 32'h0000_0fe0) : ~tlb_vaddr;
	assign ctag = cache_ack ? TAG : ~TAG;
	assign tlb_refill = tlb_ack & knob[0];
	assign tlb_invalid = tlb_ack & knob[1];
	assign cache_dirty = cache_ack ? knob[2] : ~knob[2];
	assign cache_err = cache_ack & knob[3];
	assign bus_err = bus_ack & knob[4];
endmodule : cmu_far_model

// >>> bench/cmu_top_tb.sv
`timescale 1ns/100ps
`include "cmu_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module cmu_top_tb;
	localparam logic [31:0] TAG = 32'h1234_5000;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, c0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, iss_stall, iss_done, iss_exc;
	logic iss_valid = 1'b0, iss_cp0_usable = 1'b1, iss_user_mode = 1'b0;
	logic [31:0] iss_instr = 32'h0, iss_base = 32'h0;
	cmu_pkg::cmu_exc_t iss_exc_code;
	logic tlb_req, tlb_ack, tlb_refill, tlb_invalid, tlb_coherent = 1'b0;
	logic [31:0] tlb_vaddr, tlb_paddr, cache_addr, bus_addr, ctag, va_s, ba_s;
	logic cache_req, cache_global, cache_ack, cache_dirty, cache_err, cache_valid = 1'b1;
	logic [1:0] cache_sel, cache_way, sel_a, sel_b;
	cmu_pkg::cmu_cop_t cache_op;
	logic [8:0] cache_index;
	logic bus_req, bus_ack, bus_err, sync_req, sync_ack;
	logic [5:0] knob = 6'h0;
	int error_cnt = 0, n_tests = 0, ncache = 0, nbus = 0;
	cmu_top dut_u (.*, .hready(hreadyout), .cache_tag_lo(ctag), .cache_tag_hi(~ctag),
		.cache_data_lo({ctag[15:0], ctag[31:16]}), .cache_data_hi(~ctag));
	cmu_far_model #(.TAG(TAG)) far_u (.*);
	initial forever #2.5 hclk = ~hclk;
	// ==========
	// observers of the far side
	always @(posedge hclk) begin
		if (tlb_req) va_s <= tlb_vaddr;
		if (bus_req) ba_s <= bus_addr;
		if (bus_ack) nbus <= nbus + 1;
		if (cache_ack && ncache == 0) sel_a <= cache_sel;
		if (cache_ack) sel_b <= cache_sel;
		if (cache_ack) ncache <= ncache + 1;
	end
	// ==========
	// drivers
	task automatic ahb(input logic wr, input logic [31:0] a, wd, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb
	function automatic logic [31:0] ins(input logic [2:0] op, input logic [1:0] sel,
		input logic [11:0] off);
		return {6'h0, op, sel, 9'h0, off};
	endfunction : ins
	task automatic run(input logic [31:0] i, b, input logic [5:0] k, input logic cp, us);
		knob <= k;
		iss_instr <= i;
		iss_base <= b;
		iss_cp0_usable <= cp;
		iss_user_mode <= us;
		iss_valid <= 1'b1;
		ncache = 0;
		nbus = 0;
		@(posedge hclk);
		iss_valid <= 1'b0;
		do @(posedge hclk); while (iss_done !== 1'b1);
	endtask : run
	// ==========
	// scenarios
	task automatic t_regs;
		ahb(1'b0, `CMU_REG_CTRL, 32'h0, rd);
		`CHK(rd, 32'h0)
		ahb(1'b0, 32'h1c, 32'h0, rd);
		`CHK(rd, 32'h0)
		ahb(1'b1, `CMU_REG_TAG_HIGH_HOLDING_REG, 32'h1357_9bdf, rd);
		ahb(1'b0, `CMU_REG_TAG_HIGH_HOLDING_REG, 32'h0, rd);
		`CHK(rd, 32'h1357_9bdf)
		`CHK(hresp, 1'b0)
		$display("test regs done");
	endtask : t_regs
	task automatic t_inval;
		ahb(1'b0, `CMU_REG_COUNT, 32'h0, c0);
		run(ins(3'h0, 2'h0, 12'hffc), 32'h8000_1000, 6'h00, 1'b1, 1'b0);
		`CHK(iss_exc, 1'b0)
		`CHK(va_s, 32'h8000_1000 - 32'h4)
		`CHK(sel_b, 2'h0)
		`CHK(nbus, 0)
		`CHK(iss_stall, 1'b1)
		ahb(1'b0, `CMU_REG_COUNT, 32'h0, rd);
		`CHK(rd, c0 + 32'h1)
		$display("test index invalidate done");
	endtask : t_inval
	task automatic t_dirty;
		run(ins(3'h0, 2'h1, 12'h013), 32'h0000_2aa0, 6'h24, 1'b1, 1'b0);
		`CHK(iss_exc, 1'b0)
		`CHK(va_s, 32'h0000_2aa0 + 32'h13)
		`CHK(nbus, 1)
		`CHK(ba_s, {TAG[31:12], va_s[11:5], 5'h0})
		ahb(1'b1, `CMU_REG_CTRL, 32'h2, rd);
		run(ins(3'h0, 2'h1, 12'h013), 32'h0000_2aa0, 6'h04, 1'b1, 1'b0);
		`CHK(nbus, 1)
		`CHK(ba_s, {TAG[31:12], ~va_s[11:5], 5'h0})
		ahb(1'b1, `CMU_REG_CTRL, 32'h0, rd);
		$display("test writeback done");
	endtask : t_dirty
	task automatic t_ldtag;
		run(ins(3'h1, 2'h1, 12'h040), 32'h8000_0000, 6'h08, 1'b1, 1'b0);
		`CHK(iss_exc, 1'b0)
		ahb(1'b0, `CMU_REG_TAG_LOW_HOLDING_REG, 32'h0, rd);
		`CHK(rd, TAG)
		ahb(1'b0, `CMU_REG_LINE_DATA_LOW_REG, 32'h0, rd);
		`CHK(rd, {TAG[15:0], TAG[31:16]})
		$display("test load tag done");
	endtask : t_ldtag
	task automatic t_outer;
		for (int i = 2; i < 4; i++) begin
			run(ins(3'h0, i[1:0], 12'h100), 32'h8000_0000, 6'h00, 1'b1, 1'b0);
			`CHK(sel_a, 2'h1)
			`CHK(sel_b, i[1:0])
			`CHK(ncache, 4)
			`CHK(cache_global, 1'b0)
		end
		run(ins(3'h6, 2'h1, 12'h0), 32'h8000_0000, 6'h00, 1'b1, 1'b0);
		`CHK(ncache, 0)
		$display("test outer levels done");
	endtask : t_outer
	task automatic t_faults;
		logic [5:0] kn [6] = '{6'h01, 6'h02, 6'h08, 6'h14, 6'h00, 6'h00};
		logic [1:0] cu [6] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h3};
		cmu_pkg::cmu_exc_t ex [6] = '{cmu_pkg::CMU_EXC_TLB_REFILL,
			cmu_pkg::CMU_EXC_TLB_INVALID, cmu_pkg::CMU_EXC_CACHE_ERR,
			cmu_pkg::CMU_EXC_BUS_ERR, cmu_pkg::CMU_EXC_CPU, cmu_pkg::CMU_EXC_ADDR_LOAD};
		ahb(1'b1, `CMU_REG_CTRL, 32'h1, rd);
		for (int i = 0; i < 6; i++) begin
			run(ins(3'h0, 2'h1, 12'h020), 32'h8000_0000, kn[i], cu[i][1], cu[i][0]);
			`CHK({iss_exc, iss_exc_code}, {1'b1, ex[i]})
			`CHK(ncache, (i < 2 || i > 3) ? 0 : 1)
			ahb(1'b0, `CMU_REG_STATUS, 32'h0, rd);
			`CHK(rd[6:4], ex[i])
		end
		ahb(1'b1, `CMU_REG_CTRL, 32'h0, rd);
		$display("test faults done");
	endtask : t_faults
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_inval();
		t_dirty();
		t_ldtag();
		t_outer();
		t_faults();
		results();
	end
	// whole run needs well under a thousand cycles
	initial begin
		#20000;
		error_cnt++;
		results();
	end
endmodule : cmu_top_tb
bind cmu_top cmu_asserts chk_u (.*);
